// ---- hw/cbscb_bridge.v ----
// Control-bit serial command bridge: control word in, framed ASCII out.
// Assumes synchronous inputs, register port master as described in the note.
//
// Function
// - Link defaults to 9600 baud, 8N1, no handshake.
// - Frame is STX, payload, carriage return, line feed; no acknowledge.
// - Commands translate only while control byte 0 bit 0 is one.
// - Bit 0 sends v, bit 15 sends H, bit 14 sends FACTORY_DEFAULTS_CMD.
// - Slave address of attached unit fills first two input data bytes.
// - STX is 02, line feed 0A, carriage return 0D.
// - Switch position F at power-up restores factory parameters.
`timescale 1ns/10ps
`include "cbscb_map.vh"

module cbscb_bridge (
   input wire i_mclk,
   input wire i_rst_n,
   input wire [3:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [3:0] i_mode_select_switch,
   output reg [15:0] o_rdata,
   output reg o_txd,
   output reg [15:0] o_data_range_head
);

   // ****************************************
   // Registers
   // ****************************************
   reg [15:0] ctrl;
   reg [15:0] ctrl_prev;
   reg [15:0] slave_addr;
   reg [15:0] baud_div;
   reg strap_done;
   reg [2:0] pending;

   // Mode bit doubles as the version request bit, so turning the mode on
   // with bit 0 rising also asks for the version string
   wire cmd_mode = ctrl[`CBSCB_MODE_BIT];
   wire [15:0] rise = ctrl & ~ctrl_prev;
   wire [2:0] req_rise = {rise[`CBSCB_BIT_RESTART], rise[`CBSCB_BIT_DEFAULTS], rise[`CBSCB_BIT_VERSION]};

   // Two-entry buffer between frame builder and transmitter
   reg [7:0] buf_data [0:1];
   reg buf_wp;
   reg buf_rp;
   reg [1:0] buf_cnt;
   wire buf_in_ready = (buf_cnt != 2'h2);
   wire buf_out_valid = (buf_cnt != 2'h0);
   wire buf_in_valid;
   wire buf_out_ready;
   wire [7:0] buf_in_data;
   wire buf_push;
   wire buf_pop;

   // ****************************************
   // Register port
   // ****************************************
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl <= 16'h0000;
         slave_addr <= `CBSCB_ADDR_RESET;
         baud_div <= `CBSCB_BIT_CYCLES_RESET;
         strap_done <= 1'b0;
         o_rdata <= 16'h0000;
      end else begin
         o_rdata <= 16'h0000;
         if (!strap_done) begin
            strap_done <= 1'b1;
            if (i_mode_select_switch == `CBSCB_SWITCH_DEFAULTS) begin
               slave_addr <= `CBSCB_ADDR_RESET;
               baud_div <= `CBSCB_BIT_CYCLES_RESET;
            end
         end
         if (i_wr) begin
            case (i_addr)
               `CBSCB_REG_CTRL: ctrl <= i_wdata;
               `CBSCB_REG_ADDR: slave_addr <= i_wdata;
               `CBSCB_REG_DIV: baud_div <= (i_wdata == 16'h0000) ? 16'h0001 : i_wdata;
               default: ;
            endcase
         end
         if (i_rd) begin
            case (i_addr)
               `CBSCB_REG_CTRL: o_rdata <= ctrl;
               `CBSCB_REG_CTRLB0: o_rdata <= {8'h00, ctrl[7:0]};
               `CBSCB_REG_STATUS: o_rdata <= {11'h000, buf_cnt, pending};
               `CBSCB_REG_ADDR: o_rdata <= slave_addr;
               `CBSCB_REG_DIV: o_rdata <= baud_div;
               default: o_rdata <= 16'h0000;
            endcase
         end
      end
   end

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data_range_head <= 16'h0000;
      end else begin
         o_data_range_head <= slave_addr;
      end
   end

   // ****************************************
   // Edge detection and frame building
   // ****************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_HEAD = 2'h1;
   localparam ST_BODY = 2'h2;
   localparam ST_TAIL = 2'h3;

   reg [1:0] fstate;
   reg [1:0] cmd_sel;
   reg [1:0] idx;
   reg [7:0] next_char;
   reg [1:0] body_len;
   reg [2:0] launch_mask;
   reg [2:0] next_pending;

   // ****************************************
   // Request bookkeeping
   // ****************************************
   // The launched request is cleared first and fresh edges are ORed in after,
   // so an edge that arrives in the launch cycle is never swallowed
   always @* begin
      launch_mask = 3'h0;
      if (fstate == ST_IDLE) begin
         if (pending[0]) begin
            launch_mask = 3'h1;
         end else if (pending[1]) begin
            launch_mask = 3'h2;
         end else if (pending[2]) begin
            launch_mask = 3'h4;
         end
      end
      next_pending = pending & ~launch_mask;
      if (cmd_mode) begin
         next_pending = next_pending | req_rise;
      end
   end

   // ****************************************
   // Frame sequencer
   // ****************************************
   // Pending requests are kept so that a bit rising during a frame is not lost
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_prev <= 16'h0000;
         pending <= 3'h0;
         fstate <= ST_IDLE;
         cmd_sel <= 2'h0;
         idx <= 2'h0;
      end else begin
         ctrl_prev <= ctrl;
         case (fstate)
            ST_IDLE: begin
               if (pending[0]) begin
                  cmd_sel <= 2'h0;
                  fstate <= ST_HEAD;
               end else if (pending[1]) begin
                  cmd_sel <= 2'h1;
                  fstate <= ST_HEAD;
               end else if (pending[2]) begin
                  cmd_sel <= 2'h2;
                  fstate <= ST_HEAD;
               end
               idx <= 2'h0;
            end
            ST_HEAD: if (buf_in_ready) fstate <= ST_BODY;
            ST_BODY: if (buf_in_ready) begin
               idx <= idx + 2'h1;
               if (idx == body_len) begin
                  idx <= 2'h0;
                  fstate <= ST_TAIL;
               end
            end
            ST_TAIL: if (buf_in_ready) begin
               idx <= idx + 2'h1;
               if (idx == 2'h1) begin
                  fstate <= ST_IDLE;
               end
            end
            default: fstate <= ST_IDLE;
         endcase
         // Set wins over clear: a new edge in the launch cycle stays pending
         pending <= next_pending;
      end
   end

   always @* begin
      body_len = (cmd_sel == 2'h1) ? 2'h3 : 2'h0;
      next_char = `CBSCB_STX_CHAR;
      case (fstate)
         ST_BODY: begin
            case (cmd_sel)
               2'h0: next_char = `CBSCB_VERSION_CHAR;
               2'h2: next_char = `CBSCB_RESTART_CHAR;
               default: begin
                  case (idx)
                     2'h0: next_char = `CBSCB_DEFAULTS_0;
                     2'h1: next_char = `CBSCB_DEFAULTS_1;
                     2'h2: next_char = `CBSCB_DEFAULTS_2;
                     default: next_char = `CBSCB_DEFAULTS_3;
                  endcase
               end
            endcase
         end
         ST_TAIL: next_char = (idx == 2'h0) ? `CBSCB_CARRIAGE_RETURN_CHAR : `CBSCB_LINE_FEED_CHAR;
         default: next_char = `CBSCB_STX_CHAR;
      endcase
   end

   // Every non-idle state offers one character; the sequencer only moves on
   // when the buffer takes it, so no character is dropped on a stall
   assign buf_in_valid = (fstate != ST_IDLE);
   assign buf_in_data = next_char;
   assign buf_push = buf_in_valid && buf_in_ready;
   assign buf_pop = buf_out_valid && buf_out_ready;

   // ****************************************
   // Two-entry buffer
   // ****************************************
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         buf_cnt <= 2'h0;
         buf_data[0] <= 8'h00;
         buf_data[1] <= 8'h00;
      end else begin
         if (buf_push) begin
            buf_data[buf_wp] <= buf_in_data;
            buf_wp <= ~buf_wp;
         end
         if (buf_pop) begin
            buf_rp <= ~buf_rp;
         end
         // Push and pop in one cycle leave the count as it is
         case ({buf_push, buf_pop})
            2'b10: buf_cnt <= buf_cnt + 2'h1;
            2'b01: buf_cnt <= buf_cnt - 2'h1;
            default: buf_cnt <= buf_cnt;
         endcase
      end
   end

   // ****************************************
   // 8N1 transmitter, no handshake
   // ****************************************
   reg [15:0] bit_timer;
   reg [3:0] bit_idx;
   reg [9:0] shifter;
   reg tx_busy;
   wire bit_tick;
   // The transmitter takes a character only when idle, which costs one idle
   // cycle between characters; far below one bit time, so harmless
   assign buf_out_ready = !tx_busy;
   assign bit_tick = (bit_timer == baud_div - 16'h0001);

   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_timer <= 16'h0000;
         bit_idx <= 4'h0;
         shifter <= 10'h3FF;
         tx_busy <= 1'b0;
         o_txd <= 1'b1;
      end else if (!tx_busy) begin
         o_txd <= 1'b1;
         if (buf_out_valid) begin
            shifter <= {1'b1, buf_data[buf_rp], 1'b0};
            tx_busy <= 1'b1;
            bit_idx <= 4'h0;
            bit_timer <= 16'h0000;
         end
      end else begin
         o_txd <= shifter[0];
         if (bit_tick) begin
            bit_timer <= 16'h0000;
            shifter <= {1'b1, shifter[9:1]};
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == 4'h9) tx_busy <= 1'b0;
         end else begin
            bit_timer <= bit_timer + 16'h0001;
         end
      end
   end

endmodule // cbscb_bridge

// ---- common/cbscb_map.vh ----
// Constants for the control-bit serial command bridge.
// Assumes a 10 MHz core clock and an 8N1 asynchronous serial link.
`ifndef CBSCB_MAP_VH
`define CBSCB_MAP_VH

// ****************************************
// Clock and link timing
// ****************************************
`define CBSCB_CLK_HZ 10000000
`define CBSCB_BAUD_DEFAULT 9600
`define CBSCB_BIT_CYCLES (`CBSCB_CLK_HZ / `CBSCB_BAUD_DEFAULT)
// Same figure as a 16-bit value for the divisor register
`define CBSCB_BIT_CYCLES_RESET 16'h0411
`define CBSCB_DATA_BITS 8

// ****************************************
// Frame characters
// ****************************************
`define CBSCB_STX_CHAR 8'h02
`define CBSCB_LINE_FEED_CHAR 8'h0A
`define CBSCB_CARRIAGE_RETURN_CHAR 8'h0D

// ****************************************
// Control bits and payloads
// ****************************************
`define CBSCB_MODE_BIT 0
`define CBSCB_BIT_VERSION 0
`define CBSCB_BIT_DEFAULTS 14
`define CBSCB_BIT_RESTART 15
`define CBSCB_VERSION_CHAR 8'h76
`define CBSCB_RESTART_CHAR 8'h48
`define CBSCB_DEFAULTS_0 8'h50
`define CBSCB_DEFAULTS_1 8'h43
`define CBSCB_DEFAULTS_2 8'h32
`define CBSCB_DEFAULTS_3 8'h30

// ****************************************
// Register port offsets
// ****************************************
`define CBSCB_REG_CTRL 4'h0
`define CBSCB_REG_CTRLB0 4'h1
`define CBSCB_REG_STATUS 4'h2
`define CBSCB_REG_ADDR 4'h3
`define CBSCB_REG_DIV 4'h4
`define CBSCB_ADDR_RESET 16'h0000
`define CBSCB_SWITCH_DEFAULTS 4'hF

`endif

// ---- verification/cbscb_bridge_monitor.sv ----
// Port checker for the bridge.
// Assumes it is bound to cbscb_bridge.
`timescale 1ns/10ps
`include "cbscb_map.vh"
module cbscb_bridge_monitor (
   input wire i_mclk,
   input wire i_rst_n,
   input wire [3:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [3:0] i_mode_select_switch,
   input wire [15:0] o_rdata,
   input wire o_txd,
   input wire [15:0] o_data_range_head
);
   reg [15:0] ctrl;
   reg [15:0] div;
   reg [31:0] idle;
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl <= 16'h0000;
         div <= 16'h0411;
         idle <= 32'h0;
      end else begin
         idle <= o_txd ? idle + 32'h1 : 32'h0;
         if (i_wr && i_addr == `CBSCB_REG_CTRL)
            ctrl <= i_wdata;
         if (i_wr && i_addr == `CBSCB_REG_DIV)
            div <= (i_wdata == 16'h0) ? 16'h1 : i_wdata;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   ctrl_read_a: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == ctrl) else $error("ctrl read");
   div_read_a: assert property (i_rd && i_addr == 4'h4 |=> o_rdata == div) else $error("divisor read");
   addr_read_a: assert property (i_rd && i_addr == 4'h3 |=> o_rdata == o_data_range_head) else $error("addr");
   addr_write_a: assert property (i_wr && i_addr == 4'h3 |-> ##2 o_data_range_head == $past(i_wdata, 2))
      else $error("address write");
   idle_high_a: assert property ($rose(i_rst_n) |-> o_txd) else $error("line not idle");
   head_clear_a: assert property ($rose(i_rst_n) |-> o_data_range_head == 16'h0) else $error("head");
   start_bit_a: assert property ($fell(o_txd) |-> (!o_txd) [*8]) else $error("start bit short");
   // Only from a quiet line, so a frame still in flight cannot delay the start
   frame_go_a: assert property (i_wr && i_addr == 4'h0 && i_wdata[0] && !ctrl[0] && idle > {10'h0, div, 6'h0}
      |-> ##[1:8] $fell(o_txd)) else $error("no frame start");
endmodule // cbscb_bridge_monitor
bind cbscb_bridge cbscb_bridge_monitor cbscb_bridge_monitor_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_mode_select_switch(i_mode_select_switch),
   .o_rdata(o_rdata), .o_txd(o_txd), .o_data_range_head(o_data_range_head));

// ---- verification/cbscb_unit_model.sv ----
// Attached unit: receives 8N1 characters from the bridge.
// Assumes the bench sets the bridge divisor to DIV.
`timescale 1ns/10ps
module cbscb_unit_model #(parameter int DIV = 16) (
   input wire logic i_mclk,
   input wire logic i_rxd,
   output logic [7:0] o_byte,
   output logic o_valid
);
   initial o_valid = 1'b0;
   initial o_byte = 8'h00;
   // Never answers: the link has no acknowledge and no handshake
   always begin
      @(negedge i_rxd);
      repeat (DIV / 2) @(posedge i_mclk);
      for (int n = 0; n < 8; n++) begin
         repeat (DIV) @(posedge i_mclk);
         o_byte[n] <= i_rxd;
      end
      repeat (DIV) @(posedge i_mclk);
      // A bad stop bit drops the character
      o_valid <= i_rxd;
      @(posedge i_mclk);
      o_valid <= 1'b0;
   end
endmodule // cbscb_unit_model

// ---- verification/testbench.sv ----
// Self-checking bench for the bridge.
// Assumes the unit model and the port checker.
`timescale 1ns/10ps
module testbench;
   logic i_mclk, i_rst_n, i_wr, i_rd;
   logic [3:0] i_addr, i_mode_select_switch;
   logic [15:0] i_wdata, ctrl, nv;
   wire [15:0] o_rdata, o_data_range_head;
   wire o_txd, rx_valid;
   wire [7:0] rx_byte;
   int fails, cmp_count;
   logic [7:0] expq[$], gotq[$];
   cbscb_bridge cbscb_bridge_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_mode_select_switch(i_mode_select_switch), .o_rdata(o_rdata),
      .o_txd(o_txd), .o_data_range_head(o_data_range_head));
   cbscb_unit_model #(.DIV(16)) cbscb_unit_model_i (.i_mclk(i_mclk), .i_rxd(o_txd), .o_byte(rx_byte),
      .o_valid(rx_valid));
   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) if (rx_valid === 1'b1) gotq.push_back(rx_byte);
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t char %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 cmp16(o_rdata, exp);
   endtask
   function automatic void expect_frames(input logic [15:0] old, input logic [15:0] nw);
      logic [15:0] r;
      r = nw & ~old;
      if (nw[0] && r[0]) expq = {expq, 8'h02, 8'h76, 8'h0D, 8'h0A};
      if (nw[0] && r[14]) expq = {expq, 8'h02, 8'h50, 8'h43, 8'h32, 8'h30, 8'h0D, 8'h0A};
      if (nw[0] && r[15]) expq = {expq, 8'h02, 8'h48, 8'h0D, 8'h0A};
   endfunction
   task automatic ctl(input logic [15:0] v);
      expect_frames(ctrl, v);
      ctrl = v;
      wr(4'h0, v);
      repeat (2600) @(posedge i_mclk);
      cmp16(16'(gotq.size()), 16'(expq.size()));
      while (gotq.size() > 0 && expq.size() > 0) cmp8(gotq.pop_front(), expq.pop_front());
      gotq.delete();
      expq.delete();
      rdchk(4'h0, v);
      rdchk(4'h1, {8'h00, v[7:0]});
      rdchk(4'h2, 16'h0000);
   endtask
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #6000000;
      fails++;
      finish_test;
   end
   initial begin
      i_rst_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 16'h0;
      i_mode_select_switch = 4'hC;
      ctrl = 16'h0;
      fails = 0;
      cmp_count = 0;
      void'($urandom(32'h461e));
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rdchk(4'h4, 16'h0411);
      wr(4'h4, 16'h0000);
      rdchk(4'h4, 16'h0001);
      wr(4'h4, 16'h0010);
      nv = 16'($urandom);
      wr(4'h3, nv);
      rdchk(4'h3, nv);
      cmp16(o_data_range_head, nv);
      rdchk(4'(5 + $urandom % 11), 16'h0000);
      // Mode off, then all three commands at once, then held, then re-armed
      ctl(16'hC000);
      ctl(16'h0000);
      ctl(16'hC001);
      ctl(16'hC001);
      ctl(16'h0001);
      ctl(16'hC001);
      repeat (6) ctl(16'($urandom));
      i_mode_select_switch <= 4'hF;
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rdchk(4'h3, 16'h0000);
      rdchk(4'h4, 16'h0411);
      finish_test;
   end
endmodule // testbench
